// [test/wsc_chk.sv]
// port checker for the wait-state scale control
// assumes binding onto wsc_wait_scale_control
`timescale 1ns/1ps
module wsc_chk (
  // watched ports
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic ctl_wr_i,
  input wire logic [15:0] ctl_wdata_i,
  input wire logic [15:0] ctl_rdata_o,
  input wire wsc_pkg::wsc_access_t access_i,
  input wire logic not_ready_o,
  input wire logic [2:0] wait_count_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_load;
    clk_en_i && access_i.valid && !not_ready_o;
  endsequence
  AST_RSV: assert property (ctl_rdata_o[15:5] == 11'h000) else $error("reserved bits set");
  AST_WR: assert property (clk_en_i && ctl_wr_i |=> ctl_rdata_o == {11'h000, $past(ctl_wdata_i[4:0])})
    else $error("bad readback");
  AST_HOLD: assert property (!(clk_en_i && ctl_wr_i) |=> $stable(ctl_rdata_o)) else $error("reg moved");
  AST_FRZ: assert property (!clk_en_i |=> $stable(wait_count_o) && $stable(not_ready_o))
    else $error("count moved while disabled");
  AST_NR: assert property (not_ready_o == (wait_count_o != 3'h0)) else $error("ready mismatch");
  AST_DEC: assert property (not_ready_o && clk_en_i |=> wait_count_o == $past(wait_count_o) - 3'h1)
    else $error("no count down");
  AST_LD: assert property (s_load |=> wait_count_o inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7}) else $error("bad load");
  AST_P0: assert property (s_load ##0 (access_i.space == wsc_pkg::WSC_SP_PROG && !ctl_rdata_o[0])
    |=> wait_count_o <= 3'h3) else $error("prog scale");
  AST_D1: assert property (s_load ##0 (access_i.space == wsc_pkg::WSC_SP_DATA && ctl_rdata_o[1])
    |=> wait_count_o != 3'h2) else $error("data scale");
endmodule
bind wsc_wait_scale_control wsc_chk i_chk (.*);

// [test/wsc_wait_scale_control_tb.sv]
// bench for the wait-state scale control
// assumes wsc_chk bound to the design
`timescale 1ns/1ps
module wsc_wait_scale_control_tb;
  logic clock_i = 0, rst_i = 1, cw = 0, fp = 0, fi = 0, ce = 1, nr;
  logic [15:0] wd = 16'h0000, rd;
  logic [2:0] wc;
  wsc_pkg::wsc_access_t acc = '0;
  int error_cnt = 0, check_count = 0, n;
  always #10 clock_i = ~clock_i;
  wsc_wait_scale_control i_dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(ce), .ctl_wr_i(cw),
    .ctl_wdata_i(wd), .fields_wr_pd_i(fp), .fields_wr_io_i(fi), .fields_wdata_i(wd),
    .ctl_rdata_o(rd), .access_i(acc), .not_ready_o(nr), .wait_count_o(wc));
  task chk(input string nm, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // k: 0 control, 1 program/data fields, 2 io fields
  task wr(input int k, input logic [15:0] v);
    @(negedge clock_i);
    {fi, fp, cw} = 3'b001 << k;
    wd = v;
    @(negedge clock_i);
    {fi, fp, cw} = 3'b000;
  endtask
  // counts not-ready cycles; bound cuts a hang
  task run(input int sp, input logic [15:0] a, input logic [2:0] e);
    @(negedge clock_i);
    acc = {1'b1, wsc_pkg::wsc_space_t'(sp), a};
    @(negedge clock_i);
    acc.valid = 1'b0;
    chk("load count", {13'h0, wc}, {13'h0, e});
    n = 0;
    while (nr === 1'b1 && n < 9) begin
      @(negedge clock_i);
      n++;
    end
    chk("waits", 16'(n), {13'h0, e});
    if (n > 8) test_done();
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    chk("ctl reset", rd, 16'h000F);
    wr(0, 16'hFFFF);
    chk("ctl write", rd, 16'h001F);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 2; s++) begin
        for (int f = 0; f < 4; f++) begin
          // scale first, so no space runs short meanwhile
          wr(0, s ? 16'h0001 << k : 16'h000F ^ (16'h0001 << k));
          wr(1, {8{2'(f)}});
          wr(2, {8{2'(f)}});
          run(k > 1 ? 2 : k, k == 3 ? 16'h0008 : 16'h0000, (s && f > 1) ? 3'(f * 4 - 5) : 3'(f));
        end
      end
    end
    $display("test scale done");
    wr(0, 16'h0010);
    wr(2, 16'hE4E4);
    run(2, 16'h2000, 3'h1);
    run(2, 16'hE000, 3'h3);
    run(2, 16'h000E, 3'h0);
    wr(0, 16'h0000);
    run(2, 16'h0012, 3'h1);
    run(2, 16'hE00E, 3'h3);
    $display("test io map done");
    // freeze mid-count, then reset mid-run
    wr(0, 16'h001F);
    @(negedge clock_i);
    acc = {1'b1, wsc_pkg::WSC_SP_PROG, 16'h0000};
    @(negedge clock_i);
    acc.valid = 1'b0;
    ce = 1'b0;
    repeat (4) @(negedge clock_i);
    chk("frozen count", {13'h0, wc}, 16'h0007);
    chk("frozen wait", {15'h0, nr}, 16'h0001);
    ce = 1'b1;
    @(negedge clock_i);
    rst_i = 1'b1;
    @(negedge clock_i);
    chk("reset wait", {15'h0, nr}, 16'h0000);
    chk("reset count", {13'h0, wc}, 16'h0000);
    chk("reset ctl", rd, 16'h000F);
    rst_i = 1'b0;
    run(0, 16'h0000, 3'h7);
    $display("test freeze and reset done");
    test_done();
  end
endmodule

// [verilog/wsc_params.svh]
// wait-state scale control: offsets, field positions, reset values, counts
// assumes inclusion by the package and the design module only
`ifndef WSC_PARAMS_SVH
`define WSC_PARAMS_SVH
`define WSC_REG_WIDTH 16
`define WSC_BIT_PROG 0
`define WSC_BIT_DATA 1
`define WSC_BIT_IO_LOW 2
`define WSC_BIT_IO_HIGH 3
`define WSC_BIT_BLOCK_MAP 4
`define WSC_USED_MASK 16'h001F
`define WSC_RESET_VALUE 16'h000F
`define WSC_FIELDS_RESET 16'hFFFF
`define WSC_CNT_WIDTH 3
`define WSC_CNT_ZERO 3'h0
`define WSC_CNT_ONE 3'h1
`define WSC_CNT_TWO 3'h2
`define WSC_CNT_THREE 3'h3
`define WSC_CNT_SEVEN 3'h7
`define WSC_PD_PROG_BASE 0
`define WSC_IO_FIELD_BASE 0
`define WSC_IO_BLOCK_MSB 15
`define WSC_IO_BLOCK_LSB 13
`define WSC_IO_PAIR_MSB 3
`define WSC_IO_PAIR_LSB 1
`define WSC_PD_DATA_BASE 8
`define WSC_PD_QUARTER_MSB 15
`define WSC_PD_QUARTER_LSB 14
`define WSC_IO_UPPER_FIRST 3'h4
`endif

// [verilog/wsc_pkg.sv]
// wait-state scale control: shared types
// assumes wsc_params.svh on the include path
`include "wsc_params.svh"
package wsc_pkg;
  typedef enum logic [1:0] {
    WSC_SP_PROG = 2'h0,
    WSC_SP_DATA = 2'h1,
    WSC_SP_IO = 2'h2
  } wsc_space_t;
  typedef struct packed {
    logic valid;
    wsc_space_t space;
    logic [15:0] addr;
  } wsc_access_t;
  typedef enum logic [1:0] {
    WSC_ST_IDLE = 2'b01,
    WSC_ST_WAIT = 2'b10
  } wsc_state_t;
endpackage

// [verilog/wsc_wait_scale_control.sv]
// wait-state scale control register, field decode and wait-state down-counter
// assumes a processor-side register port on clock_i and access decode from same-clock logic
//
// Contract
// R01 - block-map 0: each I/O field covers one port pair, repeating over space
// R02 - block-map 1: each I/O field covers one 8K-word block of I/O space
// R03 - bit 3 picks count mapping for upper I/O fields five to eight
// R04 - bit 2 picks count mapping for lower I/O fields one to four
// R05 - bit 1 picks count mapping for the data-space field
// R06 - bit 0 picks count mapping for the program-space field
// R07 - scale 0 gives 0,1,2,3 waits; scale 1 gives 0,1,3,7
// R08 - block-map select bit 4 resets to 0
// R09 - four scale bits reset to 1
// R10 - reserved bits 15..5 reset, read as zero, ignore writes
// R11 - software should set this register before the wait-state field registers
// R12 - access loads wait count; not-ready holds until count reaches zero
`timescale 1ns/1ps
`include "wsc_params.svh"
module wsc_wait_scale_control (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // register port
  input wire logic ctl_wr_i,
  input wire logic [15:0] ctl_wdata_i,
  input wire logic fields_wr_pd_i,
  input wire logic fields_wr_io_i,
  input wire logic [15:0] fields_wdata_i,
  output logic [15:0] ctl_rdata_o,
  // external access decode
  input wire wsc_pkg::wsc_access_t access_i,
  // wait state result
  output logic not_ready_o,
  output logic [2:0] wait_count_o
);
  logic [15:0] ctl_ff;
  logic [15:0] nxt_ctl;
  logic [1:0] pd_quarter;
  logic io_scale;
  logic [15:0] pd_fields_ff;
  logic [15:0] io_fields_ff;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  wsc_pkg::wsc_state_t state_ff;
  wsc_pkg::wsc_state_t nxt_state;
  logic [1:0] field;
  logic scale;
  logic [2:0] io_idx;
  logic [2:0] load_cnt;

  // expand a 2-bit field to its wait count; the long mapping stretches the top two codes
  function automatic logic [2:0] wsc_scale(input logic [1:0] f, input logic s);
    logic [2:0] r;
    r = `WSC_CNT_ZERO;
    case (f)
      2'h0: begin
        r = `WSC_CNT_ZERO; // [R07]
      end
      2'h1: begin
        r = `WSC_CNT_ONE; // [R07]
      end
      2'h2: begin
        r = s ? `WSC_CNT_THREE : `WSC_CNT_TWO; // [R07]
      end
      default: begin
        r = s ? `WSC_CNT_SEVEN : `WSC_CNT_THREE; // [R07]
      end
    endcase
    return r;
  endfunction

  // field number idx of a field register whose first field starts at bit base
  function automatic logic [1:0] wsc_pick(input logic [15:0] regs, input int base, input logic [2:0] idx);
    return regs[base + {idx, 1'b0} +: 2];
  endfunction

  // reserved bits masked on write, so they always read zero
  always_comb begin
    nxt_ctl = ctl_ff;
    if (ctl_wr_i) begin
      nxt_ctl = ctl_wdata_i & `WSC_USED_MASK; // [R10]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_ff <= `WSC_RESET_VALUE; // [R08] [R09] [R10]
    end else if (clk_en_i) begin
      ctl_ff <= nxt_ctl;
    end
  end

  // field registers live here only to feed the decode; their layouts are held elsewhere
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pd_fields_ff <= `WSC_FIELDS_RESET;
    end else if (clk_en_i && fields_wr_pd_i) begin
      pd_fields_ff <= fields_wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      io_fields_ff <= `WSC_FIELDS_RESET;
    end else if (clk_en_i && fields_wr_io_i) begin
      io_fields_ff <= fields_wdata_i;
    end
  end

  // readback copy so the output comes straight from a flop; costs sixteen flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_rdata_o <= `WSC_RESET_VALUE;
    end else if (clk_en_i) begin
      ctl_rdata_o <= nxt_ctl;
    end
  end

  // quarter of program or data space picks one of four fields
  assign pd_quarter = access_i.addr[`WSC_PD_QUARTER_MSB:`WSC_PD_QUARTER_LSB];

  always_comb begin
    if (ctl_ff[`WSC_BIT_BLOCK_MAP]) begin
      io_idx = access_i.addr[`WSC_IO_BLOCK_MSB:`WSC_IO_BLOCK_LSB]; // [R02]
    end else begin
      io_idx = access_i.addr[`WSC_IO_PAIR_MSB:`WSC_IO_PAIR_LSB]; // [R01]
    end
  end

  // upper half of the I/O fields has its own scale bit
  always_comb begin
    io_scale = ctl_ff[`WSC_BIT_IO_LOW]; // [R04]
    if (io_idx >= `WSC_IO_UPPER_FIRST) begin
      io_scale = ctl_ff[`WSC_BIT_IO_HIGH]; // [R03]
    end
  end

  always_comb begin
    field = 2'h0;
    scale = 1'b0;
    case (access_i.space)
      wsc_pkg::WSC_SP_PROG: begin
        field = wsc_pick(pd_fields_ff, `WSC_PD_PROG_BASE, {1'b0, pd_quarter});
        scale = ctl_ff[`WSC_BIT_PROG]; // [R06]
      end
      wsc_pkg::WSC_SP_DATA: begin
        field = wsc_pick(pd_fields_ff, `WSC_PD_DATA_BASE, {1'b0, pd_quarter});
        scale = ctl_ff[`WSC_BIT_DATA]; // [R05]
      end
      wsc_pkg::WSC_SP_IO: begin
        field = wsc_pick(io_fields_ff, `WSC_IO_FIELD_BASE, io_idx); // [R01] [R02]
        scale = io_scale; // [R03] [R04]
      end
      default: begin
        field = 2'h0;
        scale = 1'b0;
      end
    endcase
    load_cnt = wsc_scale(field, scale); // [R07]
  end

  // one access at a time; a new decode while waiting is ignored
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      wsc_pkg::WSC_ST_IDLE: begin
        if (access_i.valid && load_cnt != `WSC_CNT_ZERO) begin
          nxt_cnt = load_cnt; // [R12]
          nxt_state = wsc_pkg::WSC_ST_WAIT;
        end
      end
      wsc_pkg::WSC_ST_WAIT: begin
        nxt_cnt = cnt_ff - `WSC_CNT_ONE; // [R12]
        if (cnt_ff == `WSC_CNT_ONE) begin
          nxt_state = wsc_pkg::WSC_ST_IDLE;
        end
      end
      default: begin
        nxt_state = wsc_pkg::WSC_ST_IDLE;
        nxt_cnt = `WSC_CNT_ZERO;
      end
    endcase
  end

  // state register; a low enable freezes the wait mid-count
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= wsc_pkg::WSC_ST_IDLE;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
    end
  end

  // remaining wait count
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= `WSC_CNT_ZERO;
    end else if (clk_en_i) begin
      cnt_ff <= nxt_cnt; // [R12]
    end
  end

  // not-ready registered from the next state so it stands exactly count cycles
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      not_ready_o <= 1'b0;
    end else if (clk_en_i) begin
      not_ready_o <= (nxt_state == wsc_pkg::WSC_ST_WAIT); // [R12]
    end
  end

  // count output mirrors the counter without a cycle of lag
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wait_count_o <= `WSC_CNT_ZERO;
    end else if (clk_en_i) begin
      wait_count_o <= nxt_cnt; // [R12]
    end
  end
endmodule
